// ---- rtl/bsr_top.sv ----
// bit-triggered command sequence runner with command routing and faults
//////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1 - three words: activation in, busy, result out
// R2 - activation rising edge starts its stored sequence
// R3 - busy set once the sequence starts
// R4 - host clears activation after seeing busy
// R5 - busy clears after sequence done, activation low
// R6 - result bit shows error at request end
// R7 - sequence zero runs by itself after reset
// R8 - default store: bits 0..3 programmed, rest empty
// R9 - unknown commands rejected, not processed
// R10 - selector rests at A; serial only there
// R11 - first host command moves selector to B
// R12 - disable all messages returns selector to A
// R13 - enable all messages sets selector to B
// R14 - controller, stopped-bus and running-station faults
// R15 - reconfig flag with ids; event flag with id
// R16 - busy and result bits mirror activation bits
module bsr_top import bsr_pkg::*; #(
   parameter int unsigned NUM_BITS = BSR_NUM_BITS
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // host register words
   input wire logic [NUM_BITS-1:0] sequence_activation,
   output logic [NUM_BITS-1:0] sequence_busy,
   output logic [NUM_BITS-1:0] sequence_result,
   // command sources
   input wire bsr_cmd_t host_cmd,
   output logic host_cmd_ready,
   input wire bsr_cmd_t ser_cmd,
   output logic ser_cmd_ready,
   output logic cmd_reject,
   output logic route_b,
   // bus engine state
   output logic bus_configured,
   output logic bus_running,
   output logic display_clear,
   output logic err_report,
   // faults
   input wire bsr_fault_t fault_in,
   input wire logic fault_quit,
   output bsr_fault_t fault_flags,
   // reconfiguration and events
   input wire logic reconfig_in,
   input wire logic [7:0] group_in,
   input wire logic [7:0] segment_in,
   input wire logic reconfig_ack,
   output bsr_recfg_t reconfig_status,
   input wire logic event_in,
   input wire logic [15:0] event_id_in,
   input wire logic event_ack,
   output bsr_event_t event_status
);

   //////////////////////////////////////////////////////////////////////
   logic [NUM_BITS-1:0] act_rise;
   logic [NUM_BITS-1:0] pend_q, pend_d, busy_q, result_q;
   bsr_state_t state_q, state_d;
   logic [BSR_IDX_W-1:0] cur_q, start_idx;
   logic [BSR_STEP_W-1:0] step_q;
   logic err_q;
   logic start_now, finish_now;
   logic [7:0] seq_code, exec_code;
   logic exec_valid, exec_from_host, exec_known, exec_ok, exec_err;
   logic host_take, ser_take;
   logic host_ready_q, ser_ready_q, reject_q;
   logic route_q, route_d;
   logic configured_q, running_q, clear_q, report_q;
   bsr_fault_t flags_q;
   bsr_recfg_t recfg_q;
   bsr_event_t event_q;

   bsr_edge #(.W(NUM_BITS)) u_edge (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .level_i(sequence_activation),
      .rise_o(act_rise)
   );

   //////////////////////////////////////////////////////////////////////
   // request capture and selection
   always_comb begin
      start_idx = '0;
      for (int i = NUM_BITS - 1; i >= 0; i--) begin
         if (pend_q[i]) begin
            start_idx = BSR_IDX_W'(i);
         end
      end
   end

   assign start_now = (state_q == S_IDLE) && (|pend_q);
   assign finish_now = (state_q == S_WAIT) && !sequence_activation[cur_q];
   assign seq_code = bsr_seq_rom(cur_q, step_q); // R8

   always_comb begin
      pend_d = pend_q | act_rise; // R2
      if (start_now) begin
         pend_d[start_idx] = act_rise[start_idx];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= NUM_BITS'(BSR_POWERON_PEND); // R7
      end else begin
         pend_q <= pend_d;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // command source arbitration; the store outranks both ports
   assign host_take = host_cmd.valid && host_ready_q;
   assign ser_take = ser_cmd.valid && ser_ready_q && !host_take; // R10

   always_comb begin
      exec_valid = 1'b0;
      exec_from_host = 1'b0;
      exec_code = ser_cmd.code;
      if (state_q == S_RUN && seq_code != BSR_CMD_END) begin
         exec_valid = 1'b1;
         exec_code = seq_code;
      end else if (host_take) begin
         exec_valid = 1'b1;
         exec_from_host = 1'b1;
         exec_code = host_cmd.code;
      end else if (ser_take) begin
         exec_valid = 1'b1;
      end
   end

   assign exec_known = bsr_known(exec_code);
   assign exec_ok = exec_valid && exec_known; // R9
   assign exec_err = exec_valid && (!exec_known ||
      (exec_code == BSR_CMD_START && !configured_q));

   //////////////////////////////////////////////////////////////////////
   // sequencer
   always_comb begin
      state_d = state_q;
      case (state_q)
         S_IDLE: begin
            if (start_now) begin
               state_d = S_RUN;
            end
         end
         S_RUN: begin
            // a rejected entry aborts the rest of the sequence
            if (seq_code == BSR_CMD_END || !exec_known) begin
               state_d = S_WAIT;
            end
         end
         S_WAIT: begin
            if (finish_now) begin
               state_d = S_IDLE; // R5
            end
         end
         default: state_d = S_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= S_IDLE;
         cur_q <= '0;
         step_q <= '0;
         err_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (start_now) begin
            cur_q <= start_idx;
            step_q <= '0;
            err_q <= 1'b0;
         end else if (state_q == S_RUN && seq_code != BSR_CMD_END) begin
            step_q <= step_q + 1'b1;
            err_q <= err_q | exec_err;
         end
      end
   end

   // busy and result share the request's bit position
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= NUM_BITS'(BSR_WORD_RESET);
         result_q <= NUM_BITS'(BSR_WORD_RESET);
      end else begin
         if (start_now) begin
            busy_q[start_idx] <= 1'b1; // R3 R16
         end
         if (finish_now) begin
            busy_q[cur_q] <= 1'b0; // R5
            result_q[cur_q] <= err_q; // R6 R16
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // routing selector and port readiness
   always_comb begin
      route_d = route_q;
      if (exec_ok) begin
         if (exec_code == BSR_CMD_DISABLE) begin
            route_d = 1'b0; // R12
         end else if (exec_code == BSR_CMD_ENABLE) begin
            route_d = 1'b1; // R13
         end else if (exec_from_host) begin
            route_d = 1'b1; // R11
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         route_q <= 1'b0; // R10
         host_ready_q <= 1'b0;
         ser_ready_q <= 1'b0;
         reject_q <= 1'b0;
      end else begin
         route_q <= route_d;
         // ports wait while any stored sequence is pending or running
         host_ready_q <= (state_d == S_IDLE) && (pend_d == '0);
         ser_ready_q <= (state_d == S_IDLE) && (pend_d == '0) && !route_d;
         reject_q <= exec_valid && !exec_known; // R9
      end
   end

   //////////////////////////////////////////////////////////////////////
   // bus engine state driven by executed commands
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         configured_q <= 1'b0;
         running_q <= 1'b0;
         clear_q <= 1'b0;
         report_q <= 1'b0;
      end else begin
         clear_q <= exec_ok && exec_code == BSR_CMD_CLEAR;
         report_q <= exec_ok && exec_code == BSR_CMD_SEND_ERRS;
         if (exec_ok) begin
            case (exec_code)
               BSR_CMD_CONFIG: configured_q <= 1'b1;
               BSR_CMD_START: running_q <= configured_q;
               BSR_CMD_STOP, BSR_CMD_ALARM: running_q <= 1'b0;
               default: running_q <= running_q;
            endcase
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // faults; a new fault wins over a quit in the same cycle
   logic quit_now;
   assign quit_now = fault_quit || (exec_ok && exec_code == BSR_CMD_QUIT);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= '0;
      end else begin
         flags_q.ctrl <= (flags_q.ctrl && !quit_now) || fault_in.ctrl;
         flags_q.bus <= (flags_q.bus && !quit_now) ||
            (fault_in.bus && !running_q); // R14
         flags_q.station <= (flags_q.station && !quit_now) ||
            (fault_in.station && running_q); // R14
      end
   end

   //////////////////////////////////////////////////////////////////////
   // reconfiguration and event reporting
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         recfg_q <= '0;
      end else if (reconfig_in) begin
         recfg_q <= '{1'b1, group_in, segment_in}; // R15
      end else if (reconfig_ack) begin
         recfg_q.flag <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         event_q <= '0;
      end else if (event_in) begin
         event_q <= '{1'b1, event_id_in}; // R15
      end else if (event_ack) begin
         event_q.flag <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////
   assign sequence_busy = busy_q; // R1
   assign sequence_result = result_q; // R1
   assign host_cmd_ready = host_ready_q;
   assign ser_cmd_ready = ser_ready_q;
   assign cmd_reject = reject_q;
   assign route_b = route_q;
   assign bus_configured = configured_q;
   assign bus_running = running_q;
   assign display_clear = clear_q;
   assign err_report = report_q;
   assign fault_flags = flags_q;
   assign reconfig_status = recfg_q;
   assign event_status = event_q;

   //////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   logic [1:0] age_q;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         age_q <= 2'd0;
      end else if (age_q != 2'd3) begin
         age_q <= age_q + 2'd1;
      end
   end

   a_busy_on_start: assert property ( // R3
      start_now |=> busy_q[$past(start_idx)] && state_q == S_RUN)
      else $error("busy not set on sequence start");

   a_busy_held_act: assert property ( // R5
      (state_q == S_WAIT && sequence_activation[cur_q]) |=>
         busy_q[$past(cur_q)])
      else $error("busy cleared while activation still high");

   a_result_on_end: assert property ( // R6
      finish_now |=> !busy_q[$past(cur_q)] &&
         result_q[$past(cur_q)] == $past(err_q))
      else $error("result or busy wrong at request end");

   a_poweron_seq: assert property ( // R7
      age_q == 2'd1 |-> busy_q[0] && cur_q == '0)
      else $error("power-on sequence did not start");

   a_empty_seq_err: assert property ( // R8
      (start_now && start_idx > 4'd3) |=> ##1 state_q == S_WAIT && err_q)
      else $error("empty sequence not flagged as error");

   a_reject_cmd: assert property ( // R9
      (exec_valid && !exec_known) |=>
         reject_q && $stable(configured_q) && $stable(route_q))
      else $error("unknown command was processed");

   a_serial_gate: assert property ( // R10
      ser_take |-> !route_q)
      else $error("serial command taken at position B");

   a_host_route: assert property ( // R11
      (host_take && exec_known && host_cmd.code != BSR_CMD_DISABLE) |=>
         route_q)
      else $error("host command did not move selector to B");

   a_disable_route: assert property ( // R12
      (exec_ok && exec_code == BSR_CMD_DISABLE) |=> !route_q)
      else $error("disable all messages left selector at B");

   a_enable_route: assert property ( // R13
      (exec_ok && exec_code == BSR_CMD_ENABLE) |=> route_q)
      else $error("enable all messages left selector at A");

   a_fault_class: assert property ( // R14
      (fault_in.station && running_q) |=> flags_q.station ##1
         (flags_q.station || $past(quit_now)))
      else $error("station fault not flagged while running");

   a_recfg_capture: assert property ( // R15
      reconfig_in |=> recfg_q.flag && recfg_q.group_number ==
         $past(group_in) && recfg_q.segment_number == $past(segment_in))
      else $error("reconfig ids not captured");

   c_seq_error: cover property (finish_now && err_q);
   c_route_to_b: cover property ($rose(route_q));
   c_seq_bit1: cover property (start_now && start_idx == 4'd1);

endmodule

// ---- rtl/bsr_pkg.sv ----
// shared constants, types and sequence store for the sequence runner
package bsr_pkg;

   ////////////////////////////////////////////////////////////////////////
   localparam int unsigned BSR_NUM_BITS = 16;
   localparam int unsigned BSR_CODE_W = 8;
   localparam int unsigned BSR_IDX_W = 4;
   localparam int unsigned BSR_STEP_W = 2;

   // sequence 0 is pending straight out of reset
   localparam logic [15:0] BSR_POWERON_PEND = 16'h0001;
   localparam logic [15:0] BSR_WORD_RESET = 16'h0000;

   ////////////////////////////////////////////////////////////////////////
   // command codes
   localparam logic [7:0] BSR_CMD_CONFIG = 8'h00;
   localparam logic [7:0] BSR_CMD_START = 8'h01;
   localparam logic [7:0] BSR_CMD_STOP = 8'h02;
   localparam logic [7:0] BSR_CMD_ALARM = 8'h03;
   localparam logic [7:0] BSR_CMD_CLEAR = 8'h04;
   localparam logic [7:0] BSR_CMD_DISABLE = 8'h05;
   localparam logic [7:0] BSR_CMD_QUIT = 8'h09;
   localparam logic [7:0] BSR_CMD_ENABLE = 8'h0a;
   localparam logic [7:0] BSR_CMD_SEND_ERRS = 8'h20;
   // store markers, never legal as commands
   localparam logic [7:0] BSR_CMD_NONE = 8'hfe;
   localparam logic [7:0] BSR_CMD_END = 8'hff;

   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_RUN = 2'b01,
      S_WAIT = 2'b10
   } bsr_state_t;

   typedef struct packed {
      logic valid;
      logic [7:0] code;
   } bsr_cmd_t;

   typedef struct packed {
      logic ctrl;
      logic bus;
      logic station;
   } bsr_fault_t;

   typedef struct packed {
      logic flag;
      logic [7:0] group_number;
      logic [7:0] segment_number;
   } bsr_recfg_t;

   typedef struct packed {
      logic flag;
      logic [15:0] event_identifier;
   } bsr_event_t;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic bsr_known(input logic [7:0] code);
      case (code)
         BSR_CMD_CONFIG, BSR_CMD_START, BSR_CMD_STOP, BSR_CMD_ALARM,
         BSR_CMD_CLEAR, BSR_CMD_DISABLE, BSR_CMD_QUIT, BSR_CMD_ENABLE,
         BSR_CMD_SEND_ERRS: bsr_known = 1'b1;
         default: bsr_known = 1'b0;
      endcase
   endfunction

   // default stored programming; bits 4..15 hold nothing
   function automatic logic [7:0] bsr_seq_rom(input logic [3:0] idx,
                                              input logic [1:0] step);
      case ({idx, step})
         6'h00: bsr_seq_rom = BSR_CMD_QUIT;
         6'h01: bsr_seq_rom = BSR_CMD_CONFIG;
         6'h02: bsr_seq_rom = BSR_CMD_START;
         6'h03: bsr_seq_rom = BSR_CMD_END;
         6'h04: bsr_seq_rom = BSR_CMD_ALARM;
         6'h05: bsr_seq_rom = BSR_CMD_END;
         6'h08: bsr_seq_rom = BSR_CMD_CLEAR;
         6'h09: bsr_seq_rom = BSR_CMD_END;
         6'h0c: bsr_seq_rom = BSR_CMD_SEND_ERRS;
         6'h0d: bsr_seq_rom = BSR_CMD_END;
         default: bsr_seq_rom = BSR_CMD_NONE;
      endcase
   endfunction

endpackage

// ---- rtl/bsr_edge.sv ----
// per-bit rising edge detector for the activation word
module bsr_edge import bsr_pkg::*; #(
   parameter int unsigned W = BSR_NUM_BITS
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // level in, edge out
   input wire logic [W-1:0] level_i,
   output logic [W-1:0] rise_o
);

   logic [W-1:0] prev_q;

   genvar gi;
   generate
      for (gi = 0; gi < W; gi++) begin : g_bit
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               prev_q[gi] <= 1'b0;
            end else begin
               prev_q[gi] <= level_i[gi];
            end
         end
         assign rise_o[gi] = level_i[gi] & ~prev_q[gi];
      end
   endgenerate

endmodule

// ---- verification/bsr_host_model.sv ----
// host controller model: four-step activation handshake on one bit
module bsr_host_model import bsr_pkg::*; (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register words
   input wire logic [15:0] sequence_busy,
   input wire logic [15:0] sequence_result,
   output logic [15:0] sequence_activation,
   // bench control
   input wire logic req,
   input wire logic [3:0] idx,
   input wire logic [7:0] hold,
   output logic done,
   output logic result_bit,
   output logic hung
);
   timeunit 1ns;
   timeprecision 1ns;
   int n;
   logic [3:0] b;
   logic [7:0] h;

   initial begin
      sequence_activation = 16'h0000;
      done = 1'b0;
      result_bit = 1'b0;
      hung = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // hold lets the bench see busy stay up while activation is high
   always begin
      @(posedge sys_clk);
      if (req === 1'b1 && rst_n === 1'b1) begin
         b = idx;
         h = hold;
         sequence_activation[b] <= 1'b1;
         n = 0;
         while (sequence_busy[b] !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            n++;
         end
         repeat (h) @(posedge sys_clk);
         sequence_activation[b] <= 1'b0;
         while (sequence_busy[b] !== 1'b0 && n < 100) begin
            @(posedge sys_clk);
            n++;
         end
         if (n >= 100) hung <= 1'b1;
         // result only trusted once busy has dropped
         result_bit <= sequence_result[b];
         done <= 1'b1;
         @(posedge sys_clk);
         done <= 1'b0;
      end
   end
endmodule

// ---- verification/tb_bsr_top.sv ----
// self-checking testbench for the sequence runner
module tb_bsr_top import bsr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0;
   logic rst_n;
   logic [15:0] sequence_activation, sequence_busy, sequence_result;
   bsr_cmd_t host_cmd, ser_cmd;
   logic host_cmd_ready, ser_cmd_ready, cmd_reject, route_b;
   logic bus_configured, bus_running, display_clear, err_report;
   bsr_fault_t fault_in, fault_flags;
   logic fault_quit, reconfig_in, reconfig_ack, event_in, event_ack;
   logic [7:0] group_in, segment_in;
   logic [15:0] event_id_in;
   bsr_recfg_t reconfig_status;
   bsr_event_t event_status;
   logic req, done, result_bit, hung;
   logic [3:0] idx;
   logic [7:0] hold;
   int n_fail = 0;
   int samples_checked = 0;
   int n_clr = 0;
   int n_rpt = 0;
   int n_rej = 0;

   always #50 sys_clk = ~sys_clk;

   bsr_top bsr_top_i (.sys_clk, .rst_n, .sequence_activation,
      .sequence_busy, .sequence_result, .host_cmd, .host_cmd_ready,
      .ser_cmd, .ser_cmd_ready, .cmd_reject, .route_b, .bus_configured,
      .bus_running, .display_clear, .err_report, .fault_in, .fault_quit,
      .fault_flags, .reconfig_in, .group_in, .segment_in, .reconfig_ack,
      .reconfig_status, .event_in, .event_id_in, .event_ack,
      .event_status);

   bsr_host_model bsr_host_model_i (.sys_clk, .rst_n, .sequence_busy,
      .sequence_result, .sequence_activation, .req, .idx, .hold, .done,
      .result_bit, .hung);

   // one-cycle pulses are counted here so no task has to catch them
   always @(posedge sys_clk) begin
      if (display_clear === 1'b1) n_clr++;
      if (err_report === 1'b1) n_rpt++;
      if (cmd_reject === 1'b1) n_rej++;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic give_up();
      n_fail++;
      end_of_test();
   endtask

   task automatic chk(input string name, input logic [31:0] seen,
                      input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   task automatic wait_busy(input logic [3:0] b, input logic v);
      int n;
      n = 0;
      while (sequence_busy[b] !== v && n < 100) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 100) give_up();
   endtask

   task automatic send(input logic ser, input logic [7:0] code);
      int n;
      n = 0;
      if (ser) ser_cmd <= '{1'b1, code};
      else host_cmd <= '{1'b1, code};
      @(posedge sys_clk);
      while ((ser ? ser_cmd_ready : host_cmd_ready) !== 1'b1 && n < 100)
      begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 100) give_up();
      host_cmd <= '0;
      ser_cmd <= '0;
      @(posedge sys_clk);
   endtask

   task automatic run_bit(input logic [3:0] b, input logic [7:0] h,
                          input logic e);
      int n;
      idx <= b;
      hold <= h;
      req <= 1'b1;
      @(posedge sys_clk);
      req <= 1'b0;
      wait_busy(b, 1'b1);
      chk("busy set", sequence_busy, 16'h0001 << b);
      chk("host wait", host_cmd_ready, 1'b0);
      if (h > 6) begin
         repeat (6) @(posedge sys_clk);
         chk("busy held", sequence_busy[b], 1'b1);
      end
      n = 0;
      while (done !== 1'b1 && n < 200) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 200) give_up();
      chk("result bit", result_bit, e);
      chk("busy word", sequence_busy, 16'h0000);
      chk("result at bit", sequence_result[b], e);
   endtask

   task automatic fault_pulse(input bsr_fault_t f, input logic q);
      fault_in <= f;
      fault_quit <= q;
      @(posedge sys_clk);
      fault_in <= '0;
      fault_quit <= 1'b0;
      @(posedge sys_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_power_on();
      repeat (2) @(posedge sys_clk);
      chk("boot busy", sequence_busy, 16'h0001);
      wait_busy(4'h0, 1'b0);
      chk("boot result", sequence_result, 16'h0000);
      chk("configured", bus_configured, 1'b1);
      chk("running", bus_running, 1'b1);
      chk("route at reset", route_b, 1'b0);
   endtask

   task automatic t_route();
      send(1'b1, BSR_CMD_STOP);
      chk("serial stop", bus_running, 1'b0);
      chk("route a", route_b, 1'b0);
      send(1'b0, BSR_CMD_START);
      chk("route b", route_b, 1'b1);
      chk("restart", bus_running, 1'b1);
      @(posedge sys_clk);
      chk("serial blocked", ser_cmd_ready, 1'b0);
      send(1'b0, 8'h33);
      chk("host reject", cmd_reject, 1'b1);
      chk("route kept", route_b, 1'b1);
      send(1'b0, BSR_CMD_DISABLE);
      chk("route back", route_b, 1'b0);
      send(1'b0, BSR_CMD_ENABLE);
      chk("route on", route_b, 1'b1);
      send(1'b0, BSR_CMD_DISABLE);
      send(1'b1, 8'h77);
      chk("serial reject", cmd_reject, 1'b1);
      chk("route stays a", route_b, 1'b0);
   endtask

   task automatic t_bits();
      run_bit(4'h1, 8'h08, 1'b0);
      chk("alarm stop", bus_running, 1'b0);
      run_bit(4'h2, 8'h01, 1'b0);
      run_bit(4'h3, 8'h01, 1'b0);
      run_bit(4'h4, 8'h00, 1'b1);
      run_bit(4'hf, 8'h01, 1'b1);
      run_bit(4'h0, 8'h01, 1'b0);
      chk("boot rerun", bus_running, 1'b1);
      chk("clear pulses", n_clr, 1);
      chk("report pulses", n_rpt, 1);
      chk("reject pulses", n_rej, 4);
   endtask

   task automatic t_faults();
      fault_pulse(3'b010, 1'b0);
      chk("bus fault running", fault_flags, 3'b000);
      fault_pulse(3'b001, 1'b0);
      chk("station fault", fault_flags, 3'b001);
      fault_pulse(3'b100, 1'b0);
      chk("ctrl fault", fault_flags, 3'b101);
      fault_pulse(3'b000, 1'b1);
      chk("fault quit", fault_flags, 3'b000);
      send(1'b0, BSR_CMD_STOP);
      fault_pulse(3'b011, 1'b0);
      chk("bus fault stopped", fault_flags, 3'b010);
      send(1'b0, BSR_CMD_QUIT);
      chk("quit command", fault_flags, 3'b000);
   endtask

   task automatic t_reconfig_request_flag_event();
      group_in <= 8'h5a;
      segment_in <= 8'hc3;
      event_id_in <= 16'h1234;
      reconfig_in <= 1'b1;
      event_in <= 1'b1;
      @(posedge sys_clk);
      reconfig_in <= 1'b0;
      event_in <= 1'b0;
      @(posedge sys_clk);
      chk("reconfig", reconfig_status, 17'h15ac3);
      chk("event", event_status, 17'h11234);
      reconfig_ack <= 1'b1;
      event_ack <= 1'b1;
      @(posedge sys_clk);
      reconfig_ack <= 1'b0;
      event_ack <= 1'b0;
      @(posedge sys_clk);
      chk("reconfig ack", reconfig_status.flag, 1'b0);
      chk("event ack", event_status.flag, 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      host_cmd = '0;
      ser_cmd = '0;
      fault_in = '0;
      fault_quit = 1'b0;
      reconfig_in = 1'b0;
      reconfig_ack = 1'b0;
      event_in = 1'b0;
      event_ack = 1'b0;
      group_in = 8'h00;
      segment_in = 8'h00;
      event_id_in = 16'h0000;
      req = 1'b0;
      idx = 4'h0;
      hold = 8'h00;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_power_on();
      t_route();
      t_bits();
      t_faults();
      t_reconfig_request_flag_event();
      chk("host model hang", hung, 1'b0);
      end_of_test();
   end
endmodule
